/* File: common/tws_pkg.sv */
// Shared constants, states and carriers for the two-wire slave.
// Assumes the slave top and its synchroniser import this package whole.
//
// Operation
// - Matching address gets acknowledge in ninth clock
// - Match: interrupt and clock held low at ninth fall
// - Mismatch: no acknowledge, no interrupt, no wait
// - Address register upper seven bits, bit zero reads zero
// - Receive, 8-clock wait: hold clock, interrupt at eighth fall
// - Wait release after read: free clock, acknowledge ninth
// - Stop condition sets stop flag and interrupt
// - Transmit byte loaded, wait released, shifted on master clocks
// - Transmit: sample acknowledge at ninth rise into flag
// - Transmit: hold clock, interrupt at ninth fall
// - NACK clears acknowledge flag, then wait and interrupt
// - Read ends: slave releases wait, master stops
package tws_pkg;

	// ****************************************
	// Counts and reset values
	// ****************************************
	localparam logic [3:0] TWS_CNT_ZERO = 4'h0;  // Bit counter start
	localparam logic [3:0] TWS_BYTE_BITS = 4'h8; // Data bits per byte
	localparam logic [3:0] TWS_ACK_BIT = 4'h9;   // Clock carrying acknowledge
	localparam logic [6:0] TWS_ADDR_RST = 7'h00; // Own address after reset
	localparam logic [7:0] TWS_SHIFT_RST = 8'h00; // Shift register after reset
	localparam logic TWS_WAIT_EIGHT = 1'b0;      // Wait point select: eighth clock
	localparam logic TWS_ADDR_LSB = 1'b0;        // Fixed low bit of address register

	// ****************************************
	// Protocol states
	// ****************************************
	typedef enum logic [3:0] {
		TWS_IDLE,
		TWS_ADDR,
		TWS_ADDR_ACK,
		TWS_WAIT_ADDR,
		TWS_RX_DATA,
		TWS_WAIT_RX8,
		TWS_RX_ACK,
		TWS_WAIT_RX9,
		TWS_TX_DATA,
		TWS_TX_ACK,
		TWS_WAIT_TX
	} tws_state_t;

	// Cause of the latest interrupt pulse
	typedef enum logic [1:0] {
		TWS_EV_NONE,
		TWS_EV_ADDR_MATCH,
		TWS_EV_XFER_END,
		TWS_EV_STOP
	} tws_event_t;

	// Status carrier toward software
	typedef struct packed {
		logic start_detected_flag;
		logic stop_detected_flag;
		logic ack_detected_flag;
		logic addr_match;
		logic transmit_mode;
		logic wait_active;
	} tws_status_t;

endpackage

/* File: rtl/tws_slave.sv */
// Two-wire bus slave with address match, clock-stretch waits and
// software-released transfers in both directions.
// Assumes a single bus master; pin levels arrive unsynchronised and the
// bus clock is also fed to scl_clk as the link-side clock.
`timescale 1ns/100ps
module tws_slave
	import tws_pkg::*;
(
	// System clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Link clock, the bus clock line itself
	input wire logic scl_clk,
	// Bus clock line, open drain
	input wire logic serial_clock_line_i,
	output logic serial_clock_line_o,
	output logic serial_clock_line_oe_n,
	// Bus data line, open drain
	input wire logic serial_data_line_i,
	output logic serial_data_line_o,
	output logic serial_data_line_oe_n,
	// Own address programming
	input wire logic local_addr_wr,
	input wire logic [7:0] local_addr_wdata,
	output logic [7:0] local_address_reg,
	// Transfer control
	input wire logic wait_point_select,
	input wire logic ack_enable,
	input wire logic wait_release,
	input wire logic tx_load,
	input wire logic [7:0] tx_byte,
	// Data and status
	output logic [7:0] shift_data_reg,
	output logic serial_event_interrupt,
	output tws_event_t event_cause,
	output tws_status_t status
);

	// ****************************************
	// Reset release
	// ****************************************
	logic [1:0] rst_sync_r; // Release shift chain
	logic rst_n;            // Synchronised reset for the system side

	// Assert at once, release after two edges
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_r <= 2'b00;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	// ****************************************
	// Link side bit capture
	// ****************************************
	logic lnk_bit_r; // Data level at latest clock rise
	logic lnk_tgl_r; // Flips once per clock rise

	// Sample data on every bus clock rise; the link clock may stop, so the
	// raw reset is used here and only forces constants
	always_ff @(posedge scl_clk or negedge arst_n) begin
		if (!arst_n) begin
			lnk_bit_r <= 1'b0;
			lnk_tgl_r <= 1'b0;
		end else begin
			lnk_bit_r <= serial_data_line_i;
			lnk_tgl_r <= ~lnk_tgl_r;
		end
	end

	// ****************************************
	// Crossing into the system clock
	// ****************************************
	logic [2:0] sync_s;  // Synchronised clock, data, toggle
	logic scl_s;         // Bus clock level
	logic sda_s;         // Bus data level
	logic tgl_s;         // Bit toggle
	logic scl_d_r;       // Clock level one cycle back
	logic sda_d_r;       // Data level one cycle back
	logic tgl_d_r;       // Toggle one cycle back

	tws_sync #(.W(3)) u_sync (
		.clk(sys_clk),
		.rst_n(rst_n),
		.async_in({serial_clock_line_i, serial_data_line_i, lnk_tgl_r}),
		.sync_out(sync_s)
	);
	assign scl_s = sync_s[2];
	assign sda_s = sync_s[1];
	assign tgl_s = sync_s[0];

	// Delayed copies for edge detection
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			// Same level as the synchroniser's reset, so no false fall
			scl_d_r <= 1'b0;
			sda_d_r <= 1'b0;
			tgl_d_r <= 1'b0;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
			tgl_d_r <= tgl_s;
		end
	end

	// ****************************************
	// Bus events
	// ****************************************
	logic scl_fall;   // Bus clock fell
	logic start_cond; // Data fell with clock high
	logic stop_cond;  // Data rose with clock high
	logic bit_evt;    // A bit was sampled on a clock rise
	logic addr_hit;   // Received address equals own address

	assign scl_fall = scl_d_r & ~scl_s;
	assign start_cond = scl_s & scl_d_r & sda_d_r & ~sda_s;
	assign stop_cond = scl_s & scl_d_r & ~sda_d_r & sda_s;
	assign bit_evt = tgl_s ^ tgl_d_r;

	// ****************************************
	// Protocol registers
	// ****************************************
	tws_state_t state_r, state_nxt;     // Protocol state
	logic [3:0] cnt_r, cnt_nxt;         // Clock rises in this byte
	logic [7:0] sh_r, sh_nxt;           // Shared shift register
	logic [6:0] addr_r, addr_nxt;       // Own address
	logic dir_r, dir_nxt;               // Master reads from us
	logic sda_low_r, sda_low_nxt;       // Pull data line low
	logic scl_low_r, scl_low_nxt;       // Hold clock line low
	logic ackd_r, ackd_nxt;             // Acknowledge detected
	logic stopd_r, stopd_nxt;           // Stop detected
	logic startd_r, startd_nxt;         // Start detected
	logic match_r, match_nxt;           // Addressed in this transfer
	logic irq_nxt;                      // Interrupt pulse next cycle
	tws_event_t cause_nxt;              // Interrupt cause next cycle
	logic byte_done;                    // Fall after eighth rise
	logic ack_done;                     // Fall after ninth rise

	assign addr_hit = (sh_r[7:1] == addr_r);
	assign byte_done = scl_fall && (cnt_r == TWS_BYTE_BITS);
	assign ack_done = scl_fall && (cnt_r == TWS_ACK_BIT);

	// ****************************************
	// Next-state decode
	// ****************************************
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		sh_nxt = sh_r;
		addr_nxt = addr_r;
		dir_nxt = dir_r;
		sda_low_nxt = sda_low_r;
		scl_low_nxt = scl_low_r;
		ackd_nxt = ackd_r;
		stopd_nxt = stopd_r;
		startd_nxt = startd_r;
		match_nxt = match_r;
		irq_nxt = 1'b0;
		cause_nxt = TWS_EV_NONE;

		// Software writes, any time
		if (local_addr_wr) begin
			addr_nxt = local_addr_wdata[7:1];
		end
		if (tx_load) begin
			sh_nxt = tx_byte;
		end
		// The first eight sampled bits of each byte shift in, in both directions
		if (bit_evt) begin
			cnt_nxt = cnt_r + 4'h1;
			if (cnt_r < TWS_BYTE_BITS) begin
				sh_nxt = {sh_r[6:0], lnk_bit_r};
			end
		end

		unique case (state_r)
			TWS_IDLE: begin
				sda_low_nxt = 1'b0;
				scl_low_nxt = 1'b0;
			end
			// Address byte arriving
			TWS_ADDR: begin
				if (byte_done) begin
					if (addr_hit) begin
						sda_low_nxt = 1'b1;
						dir_nxt = sh_r[0];
						match_nxt = 1'b1;
						state_nxt = TWS_ADDR_ACK;
					end else begin
						state_nxt = TWS_IDLE;
					end
				end
			end
			// Acknowledge of address on ninth clock
			TWS_ADDR_ACK: begin
				if (ack_done) begin
					sda_low_nxt = 1'b0;
					scl_low_nxt = 1'b1;
					irq_nxt = 1'b1;
					cause_nxt = TWS_EV_ADDR_MATCH;
					state_nxt = TWS_WAIT_ADDR;
				end
			end
			// Wait after address, direction decides what follows
			TWS_WAIT_ADDR: begin
				if (wait_release) begin
					scl_low_nxt = 1'b0;
					cnt_nxt = TWS_CNT_ZERO;
					if (dir_r) begin
						sda_low_nxt = ~sh_nxt[7];
						state_nxt = TWS_TX_DATA;
					end else begin
						state_nxt = TWS_RX_DATA;
					end
				end
			end
			// Receiving a data byte
			TWS_RX_DATA: begin
				if (byte_done) begin
					if (wait_point_select == TWS_WAIT_EIGHT) begin
						scl_low_nxt = 1'b1;
						irq_nxt = 1'b1;
						cause_nxt = TWS_EV_XFER_END;
						state_nxt = TWS_WAIT_RX8;
					end else begin
						sda_low_nxt = ack_enable;
						state_nxt = TWS_RX_ACK;
					end
				end
			end
			// Wait before acknowledge of received byte
			TWS_WAIT_RX8: begin
				if (wait_release) begin
					scl_low_nxt = 1'b0;
					sda_low_nxt = ack_enable;
					state_nxt = TWS_RX_ACK;
				end
			end
			// Acknowledge clock of a received byte
			TWS_RX_ACK: begin
				if (ack_done) begin
					sda_low_nxt = 1'b0;
					cnt_nxt = TWS_CNT_ZERO;
					if (wait_point_select != TWS_WAIT_EIGHT) begin
						scl_low_nxt = 1'b1;
						irq_nxt = 1'b1;
						cause_nxt = TWS_EV_XFER_END;
						state_nxt = TWS_WAIT_RX9;
					end else begin
						state_nxt = TWS_RX_DATA;
					end
				end
			end
			// Wait after acknowledge of received byte
			TWS_WAIT_RX9: begin
				if (wait_release) begin
					scl_low_nxt = 1'b0;
					state_nxt = TWS_RX_DATA;
				end
			end
			// Sending a byte, next bit placed on each fall
			TWS_TX_DATA: begin
				if (byte_done) begin
					sda_low_nxt = 1'b0;
					state_nxt = TWS_TX_ACK;
				end else if (scl_fall) begin
					sda_low_nxt = ~sh_r[7];
				end
			end
			// Master acknowledge of a sent byte
			TWS_TX_ACK: begin
				if (bit_evt && (cnt_r == TWS_BYTE_BITS)) begin
					ackd_nxt = ~lnk_bit_r;
				end
				if (ack_done) begin
					scl_low_nxt = 1'b1;
					irq_nxt = 1'b1;
					cause_nxt = TWS_EV_XFER_END;
					state_nxt = TWS_WAIT_TX;
				end
			end
			// Wait for next byte, or end after NACK
			TWS_WAIT_TX: begin
				if (wait_release) begin
					scl_low_nxt = 1'b0;
					cnt_nxt = TWS_CNT_ZERO;
					if (ackd_r) begin
						sda_low_nxt = ~sh_nxt[7];
						state_nxt = TWS_TX_DATA;
					end else begin
						state_nxt = TWS_IDLE;
					end
				end
			end
			default: begin
				state_nxt = TWS_IDLE;
			end
		endcase

		// Start or restart restarts the address phase
		if (start_cond) begin
			state_nxt = TWS_ADDR;
			cnt_nxt = TWS_CNT_ZERO;
			sda_low_nxt = 1'b0;
			scl_low_nxt = 1'b0;
			startd_nxt = 1'b1;
			stopd_nxt = 1'b0;
			match_nxt = 1'b0;
		end
		// Stop ends everything and always signals
		if (stop_cond) begin
			state_nxt = TWS_IDLE;
			sda_low_nxt = 1'b0;
			scl_low_nxt = 1'b0;
			stopd_nxt = 1'b1;
			startd_nxt = 1'b0;
			match_nxt = 1'b0;
			irq_nxt = 1'b1;
			cause_nxt = TWS_EV_STOP;
		end
	end

	// ****************************************
	// State registers
	// ****************************************
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= TWS_IDLE;
			cnt_r <= TWS_CNT_ZERO;
			sh_r <= TWS_SHIFT_RST;
			addr_r <= TWS_ADDR_RST;
			dir_r <= 1'b0;
			sda_low_r <= 1'b0;
			scl_low_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			addr_r <= addr_nxt;
			dir_r <= dir_nxt;
			sda_low_r <= sda_low_nxt;
			scl_low_r <= scl_low_nxt;
		end
	end

	// Flags, cleared only by bus conditions
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ackd_r <= 1'b0;
			stopd_r <= 1'b0;
			startd_r <= 1'b0;
			match_r <= 1'b0;
		end else begin
			ackd_r <= ackd_nxt;
			stopd_r <= stopd_nxt;
			startd_r <= startd_nxt;
			match_r <= match_nxt;
		end
	end

	// ****************************************
	// Output registers
	// ****************************************
	// Pins: level always low, enable active low pulls the line
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			serial_clock_line_o <= 1'b0;
			serial_clock_line_oe_n <= 1'b1;
			serial_data_line_o <= 1'b0;
			serial_data_line_oe_n <= 1'b1;
		end else begin
			serial_clock_line_o <= 1'b0;
			serial_clock_line_oe_n <= ~scl_low_nxt;
			serial_data_line_o <= 1'b0;
			serial_data_line_oe_n <= ~sda_low_nxt;
		end
	end

	// Software-facing copies
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			local_address_reg <= {TWS_ADDR_RST, TWS_ADDR_LSB};
			shift_data_reg <= TWS_SHIFT_RST;
			serial_event_interrupt <= 1'b0;
			event_cause <= TWS_EV_NONE;
			status <= '0;
		end else begin
			local_address_reg <= {addr_nxt, TWS_ADDR_LSB};
			shift_data_reg <= sh_nxt;
			serial_event_interrupt <= irq_nxt;
			event_cause <= irq_nxt ? cause_nxt : event_cause;
			status <= '{start_detected_flag: startd_nxt, stop_detected_flag: stopd_nxt,
				ack_detected_flag: ackd_nxt, addr_match: match_nxt,
				transmit_mode: dir_nxt, wait_active: scl_low_nxt};
		end
	end

endmodule

/* File: rtl/tws_sync.sv */
// Two-stage synchroniser for a group of independent levels.
// Assumes each bit is a level that may change at any time.
`timescale 1ns/100ps
module tws_sync
	import tws_pkg::*;
#(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Levels in and out
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	// ****************************************
	// Stages
	// ****************************************
	logic [W-1:0] meta_r; // First stage, read only by second

	// Two flip-flops in series
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			sync_out <= '0;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule

/* File: verification/tws_master_model.sv */
// Behavioural single bus master driving both open-drain wires.
// Assumes pull-ups on the wires; the clock stands high between frames.
`timescale 1ns/100ps
module tws_master_model (
	// Resolved bus wires
	input wire logic scl_w,
	input wire logic sda_w,
	// Pull enables, low pulls the wire
	output logic scl_oe_n,
	output logic sda_oe_n
);
	localparam realtime Q = 31.25; // Quarter of the 125 ns bus clock
	initial begin
		scl_oe_n = 1'b1;
		sda_oe_n = 1'b1;
	end
	// Let clock rise, wait out any stretch, sample data
	task automatic rise(output logic b);
		scl_oe_n = 1'b1;
		wait (scl_w === 1'b1);
		b = sda_w;
		#(2 * Q);
	endtask
	task automatic bit_xfer(input logic o, output logic b);
		sda_oe_n = o;
		#Q;
		rise(b);
		scl_oe_n = 1'b0;
		#Q;
	endtask
	// Data low with clock high, then clock low
	task automatic start();
		sda_oe_n = 1'b0;
		#(2 * Q);
		scl_oe_n = 1'b0;
		#Q;
	endtask
	task automatic restart();
		logic b;
		sda_oe_n = 1'b1;
		#Q;
		rise(b);
		start();
	endtask
	// Data low, clock up once the slave frees it, then data up
	task automatic stop();
		logic b;
		sda_oe_n = 1'b0;
		#Q;
		rise(b);
		sda_oe_n = 1'b1;
		#(2 * Q);
	endtask
	// Returns after the ninth clock; the next byte's first rise waits out any wait
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(d[i], b);
		end
		bit_xfer(1'b1, b);
		ack = !b;
	endtask
	// Ack the byte when ack is set, NACK it otherwise
	task automatic rbyte(input logic ack, output logic [7:0] d);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(1'b1, d[i]);
		end
		bit_xfer(!ack, b);
	endtask
endmodule

/* File: verification/tws_slave_assertions.sv */
// Concurrent checks on the ports of the two-wire slave top.
// Assumes both bus wires are resolved with pull-ups outside the slave.
`timescale 1ns/100ps
module tws_slave_assertions
	import tws_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Bus wires and pull enables
	input wire logic serial_clock_line_i,
	input wire logic serial_clock_line_o,
	input wire logic serial_clock_line_oe_n,
	input wire logic serial_data_line_i,
	input wire logic serial_data_line_o,
	input wire logic serial_data_line_oe_n,
	// Software side
	input wire logic local_addr_wr,
	input wire logic [7:0] local_addr_wdata,
	input wire logic [7:0] local_address_reg,
	input wire logic wait_release,
	input wire logic serial_event_interrupt,
	input wire tws_event_t event_cause,
	input wire tws_status_t status
);
	// ****************************************
	// Properties on the system clock
	// ****************************************
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);

	chk_only_pull_low: assert property (serial_clock_line_o == 1'b0 && serial_data_line_o == 1'b0)
		else $error("open-drain line driven high");
	chk_addr_write: assert property (local_addr_wr |=> local_address_reg == ($past(local_addr_wdata) & 8'hfe))
		else $error("own address not stored in upper bits");
	chk_addr_lsb_zero: assert property (local_address_reg[0] == TWS_ADDR_LSB)
		else $error("own address low bit not zero");
	chk_wait_irq: assert property ($fell(serial_clock_line_oe_n) |-> serial_event_interrupt)
		else $error("wait entered without event pulse");
	chk_wait_after_fall: assert property ($fell(serial_clock_line_oe_n) |-> !$past(serial_clock_line_i, 2))
		else $error("wait entered while bus clock high");
	chk_wait_release: assert property (!serial_clock_line_oe_n && wait_release |=> serial_clock_line_oe_n)
		else $error("wait not released");
	chk_wait_holds: assert property (!serial_clock_line_oe_n && !wait_release |=> !serial_clock_line_oe_n)
		else $error("wait dropped without release");
	chk_stop_event: assert property ($rose(serial_data_line_i) && serial_clock_line_i
		|-> ##[1:6] (serial_event_interrupt && event_cause == TWS_EV_STOP))
		else $error("stop condition without stop event");
	chk_data_clk_low: assert property ($changed(serial_data_line_oe_n) |-> !$past(serial_clock_line_i))
		else $error("data pull changed while clock high");

	// Main scenarios reached
	cover property ($fell(serial_clock_line_oe_n));
	cover property (serial_event_interrupt && event_cause == TWS_EV_STOP);
	cover property (!serial_clock_line_oe_n && wait_release);
	cover property (!serial_data_line_oe_n && status.transmit_mode);
endmodule

bind tws_slave tws_slave_assertions i_chk (.sys_clk, .arst_n, .serial_clock_line_i, .serial_clock_line_o,
	.serial_clock_line_oe_n, .serial_data_line_i, .serial_data_line_o, .serial_data_line_oe_n, .local_addr_wr,
	.local_addr_wdata, .local_address_reg, .wait_release, .serial_event_interrupt, .event_cause, .status);

/* File: verification/tws_slave_bench.sv */
// Self-checking bench for the two-wire slave with a master model.
// Assumes pull-ups on both wires; software acts on each event pulse.
`timescale 1ns/100ps
module tws_slave_bench
	import tws_pkg::*;
;
	typedef struct packed {tws_event_t c; logic [1:0] k; logic [7:0] v;} tws_note_t; // Expected event
	logic sys_clk = 0, arst_n = 0, local_addr_wr = 0, wait_point_select = 0, ack_enable = 1;
	logic wait_release = 0, tx_load = 0, scl_o, scl_oe_n, sda_o, sda_oe_n, irq, m_scl, m_sda, a;
	logic [7:0] local_addr_wdata = 0, tx_byte = 0, lreg, sreg, d;
	logic [7:0] e [2];
	logic [6:0] own;
	tws_event_t cause;
	tws_status_t st;
	tws_note_t notes [$];
	tws_note_t nt;
	logic [7:0] txq [$];
	integer seed = 32'hbaa0c1c0;
	int fails = 0, n_checks = 0;
	wire scl_w = (scl_oe_n | scl_o) & m_scl; // Pulled-up clock wire
	wire sda_w = (sda_oe_n | sda_o) & m_sda; // Pulled-up data wire

	tws_slave i_dut (.sys_clk, .arst_n, .scl_clk(scl_w), .serial_clock_line_i(scl_w), .serial_clock_line_o(scl_o),
		.serial_clock_line_oe_n(scl_oe_n), .serial_data_line_i(sda_w), .serial_data_line_o(sda_o),
		.serial_data_line_oe_n(sda_oe_n), .local_addr_wr, .local_addr_wdata, .local_address_reg(lreg),
		.wait_point_select, .ack_enable, .wait_release, .tx_load, .tx_byte, .shift_data_reg(sreg),
		.serial_event_interrupt(irq), .event_cause(cause), .status(st));
	tws_master_model i_mst (.scl_w, .sda_w, .scl_oe_n(m_scl), .sda_oe_n(m_sda));

	initial begin
		forever #2 sys_clk = ~sys_clk;
	end
	task automatic check(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'b1) begin
			fails++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Oldest note against each event pulse
	always @(negedge sys_clk) begin
		if (irq === 1'b1) begin
			if (notes.size() == 0) begin
				check(1'b0, "unexpected event");
			end else begin
				nt = notes.pop_front();
				check(cause === nt.c, "event cause");
				if (nt.k == 2'd1) check(sreg === nt.v, "received byte");
				if (nt.k == 2'd2) check(st.ack_detected_flag === nt.v[0] && st.transmit_mode === 1'b1, "ack flag");
				check(st.wait_active === (nt.c != TWS_EV_STOP), "wait status");
				check(st.addr_match === (nt.c != TWS_EV_STOP), "match status");
				check(st.start_detected_flag === (nt.c != TWS_EV_STOP), "start flag");
				check(st.stop_detected_flag === (nt.c == TWS_EV_STOP), "stop flag at event");
			end
		end
	end
	// Software: load next byte when sending, releasing in the same cycle
	initial begin
		forever begin
			@(negedge sys_clk);
			wait_release = 1'b0;
			tx_load = 1'b0;
			if (irq === 1'b1) begin
				repeat (2) @(negedge sys_clk);
				if (st.transmit_mode === 1'b1 && txq.size() > 0) begin
					tx_byte = txq.pop_front();
					tx_load = 1'b1;
				end
				wait_release = 1'b1;
			end
		end
	end
	initial begin
		#200000;
		check(1'b0, "timeout");
		complete_run();
	end
	initial begin
		repeat (4) @(negedge sys_clk);
		check(lreg === 8'h00 && scl_oe_n === 1'b1 && sda_oe_n === 1'b1, "reset values");
		arst_n = 1'b1;
		repeat (3) @(negedge sys_clk);
		own = 7'($random(seed));
		local_addr_wdata = {own, 1'b1};
		local_addr_wr = 1'b1;
		@(negedge sys_clk);
		local_addr_wr = 1'b0;
		@(negedge sys_clk);
		check(lreg === {own, 1'b0}, "own address");
		// Write frame, last byte in nine-clock mode with NACK
		i_mst.start();
		notes.push_back('{TWS_EV_ADDR_MATCH, 2'd0, 8'h00});
		i_mst.wbyte({own, 1'b0}, a);
		check(a === 1'b1, "address ack");
		for (int i = 0; i < 3; i++) begin
			@(negedge sys_clk);
			d = 8'($random(seed));
			wait_point_select = (i == 2);
			ack_enable = (i != 2);
			notes.push_back('{TWS_EV_XFER_END, 2'd1, d});
			i_mst.wbyte(d, a);
			check(a === (i != 2), "data ack");
		end
		// Read frame after restart, ACK then NACK
		e[0] = 8'($random(seed));
		e[1] = 8'($random(seed));
		txq.push_back(e[0]);
		txq.push_back(e[1]);
		i_mst.restart();
		notes.push_back('{TWS_EV_ADDR_MATCH, 2'd0, 8'h00});
		i_mst.wbyte({own, 1'b1}, a);
		check(a === 1'b1, "read address ack");
		for (int i = 0; i < 2; i++) begin
			notes.push_back('{TWS_EV_XFER_END, 2'd2, {7'h00, i == 0}});
			i_mst.rbyte(i == 0, d);
			check(d === e[i], "transmitted byte");
		end
		notes.push_back('{TWS_EV_STOP, 2'd0, 8'h00});
		i_mst.stop();
		repeat (8) @(negedge sys_clk);
		check(st.stop_detected_flag === 1'b1, "stop flag");
		// Foreign address: no ack, no wait, no event before the stop event
		i_mst.start();
		i_mst.wbyte({own ^ 7'h01, 1'b0}, a);
		check(a === 1'b0 && scl_oe_n === 1'b1, "mismatch frame");
		notes.push_back('{TWS_EV_STOP, 2'd0, 8'h00});
		i_mst.stop();
		repeat (8) @(negedge sys_clk);
		check(notes.size() == 0, "events missing");
		complete_run();
	end
endmodule
